// File: flash_status_defines.svh
// Constants for the flash write-status polling controller.
`ifndef FLASH_STATUS_DEFINES_SVH
`define FLASH_STATUS_DEFINES_SVH
`define POLL_BIT_POS 7
`define TOGGLE_BIT_POS 6
`define TIMEOUT_BIT_POS 5
`define SECTOR_TOGGLE_POS 2
`define RESET_CMD_DATA 8'hF0
`define STROBE_LOW_NS 80
`define STROBE_HIGH_NS 40
`define CLK_PERIOD_NS 20
`define STROBE_LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: flash_status_pkg.sv
// Types for the flash write-status polling controller.
package flash_status_pkg;
	typedef enum logic [1:0] {
		MODE_POLL_BIT,
		MODE_TOGGLE
	} poll_mode_t;
	typedef enum logic [1:0] {
		RES_NONE,
		RES_DONE,
		RES_FAIL
	} poll_result_t;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RD_LOW,
		ST_RD_HIGH,
		ST_EVAL,
		ST_WR_LOW,
		ST_WR_HIGH,
		ST_FINISH
	} poll_state_t;
endpackage

// File: flash_status_poller.sv
// Host-side controller that polls flash write status and recovers from failures.
`timescale 1ns/1ps
`include "flash_status_defines.svh"

// Functional notes
// - Host polls at program or erase-sector address.
// - Full byte valid only after poll true.
// - Host compares two reads; equal means done.
// - Toggling with timeout set: recheck, then fail.
// - Resumed polling restarts from first read pair.
// - Reread poll bit after timeout bit seen.
// - Host sends reset after any timeout failure; abort_i high at the failing recheck ends the job without it.
// - Reset is one write of F0.
module flash_status_poller (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic toggle_mode_i,
	input wire logic [18:0] poll_addr_i,
	input wire logic [7:0] expect_data_i,
	input wire logic is_erase_i,
	input wire logic abort_i,
	output logic busy_o,
	output logic done_o,
	output logic fail_o,
	output logic [7:0] final_data_o,
	output logic in_erase_sector_o,
	output logic [18:0] addr_o,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o,
	output logic dq_oe_o
);
	flash_status_pkg::poll_state_t state_ff, nxt_state;
	flash_status_pkg::poll_mode_t mode_ff;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] prev_ff;
	logic have_prev_ff;
	logic saw_timeout_ff;
	logic want_data_ff;
	logic erase_ff;
	logic [7:0] exp_ff;
	logic [18:0] addr_ff;
	logic [7:0] final_ff;
	logic done_ff, fail_ff, sect_ff;
	logic [7:0] rd_ff;

	// Bit select helper used for the status byte fields.
	function automatic logic bit_of(input logic [7:0] b, input int pos);
		return b[pos];
	endfunction

	// Status decode of the latest read byte.
	wire poll_true = bit_of(rd_ff, `POLL_BIT_POS) ==
		(erase_ff ? 1'b1 : bit_of(exp_ff, `POLL_BIT_POS));
	wire toggled = bit_of(rd_ff, `TOGGLE_BIT_POS) != bit_of(prev_ff, `TOGGLE_BIT_POS);
	wire timeout_seen = bit_of(rd_ff, `TIMEOUT_BIT_POS);
	wire sect_toggled = bit_of(rd_ff, `SECTOR_TOGGLE_POS) !=
		bit_of(prev_ff, `SECTOR_TOGGLE_POS);
	wire rd_phase = (state_ff == flash_status_pkg::ST_RD_LOW) ||
		(state_ff == flash_status_pkg::ST_RD_HIGH);
	wire wr_phase = (state_ff == flash_status_pkg::ST_WR_LOW) ||
		(state_ff == flash_status_pkg::ST_WR_HIGH);

	// Strobe and bus drive; the reset write lands on any address.
	assign ce_n_o = !(rd_phase || wr_phase);
	assign oe_n_o = (state_ff != flash_status_pkg::ST_RD_LOW);
	assign we_n_o = (state_ff != flash_status_pkg::ST_WR_LOW);
	assign dq_oe_o = wr_phase;
	assign dq_o = `RESET_CMD_DATA;
	assign addr_o = addr_ff;
	assign busy_o = (state_ff != flash_status_pkg::ST_IDLE);
	assign done_o = done_ff;
	assign fail_o = fail_ff;
	assign final_data_o = final_ff;
	assign in_erase_sector_o = sect_ff;

	// Sequencer next state; each read cycle ends with a strobe rise, which
	// is what advances the device's toggle bits.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			flash_status_pkg::ST_IDLE: begin
				nxt_cnt = 4'h0;
				if (start_i) begin
					nxt_state = flash_status_pkg::ST_RD_LOW;
				end
			end
			flash_status_pkg::ST_RD_LOW: begin
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff == 4'(`STROBE_LOW_CYC - 1)) begin
					nxt_state = flash_status_pkg::ST_RD_HIGH;
					nxt_cnt = 4'h0;
				end
			end
			flash_status_pkg::ST_RD_HIGH: begin
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff == 4'(`STROBE_HIGH_CYC - 1)) begin
					nxt_state = flash_status_pkg::ST_EVAL;
					nxt_cnt = 4'h0;
				end
			end
			flash_status_pkg::ST_EVAL: begin
				nxt_state = flash_status_pkg::ST_RD_LOW;
				if (abort_i) begin
					nxt_state = flash_status_pkg::ST_FINISH;
				end else if (want_data_ff) begin
					nxt_state = flash_status_pkg::ST_FINISH;
				end else if (mode_ff == flash_status_pkg::MODE_POLL_BIT) begin
					if (!poll_true && saw_timeout_ff) begin
						nxt_state = flash_status_pkg::ST_WR_LOW;
					end
				end else if (have_prev_ff && toggled && saw_timeout_ff) begin
					nxt_state = flash_status_pkg::ST_WR_LOW;
				end
			end
			flash_status_pkg::ST_WR_LOW: begin
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff == 4'(`STROBE_LOW_CYC - 1)) begin
					nxt_state = flash_status_pkg::ST_WR_HIGH;
					nxt_cnt = 4'h0;
				end
			end
			flash_status_pkg::ST_WR_HIGH: begin
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff == 4'(`STROBE_HIGH_CYC - 1)) begin
					nxt_state = flash_status_pkg::ST_FINISH;
					nxt_cnt = 4'h0;
				end
			end
			flash_status_pkg::ST_FINISH: begin
				nxt_state = flash_status_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = flash_status_pkg::ST_IDLE;
			end
		endcase
	end

	// State and strobe timer.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state_ff <= flash_status_pkg::ST_IDLE;
			cnt_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// Data capture happens on the same clock edge where the output enable rises.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rd_ff <= 8'h00;
		end else if (state_ff == flash_status_pkg::ST_RD_LOW &&
			cnt_ff == 4'(`STROBE_LOW_CYC - 1)) begin
			rd_ff <= dq_i;
		end
	end

	// Job setup on start; a new job always restarts the read pair.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			mode_ff <= flash_status_pkg::MODE_POLL_BIT;
			erase_ff <= 1'b0;
			exp_ff <= 8'h00;
			addr_ff <= 19'h0_0000;
		end else if (state_ff == flash_status_pkg::ST_IDLE && start_i) begin
			mode_ff <= toggle_mode_i ? flash_status_pkg::MODE_TOGGLE
				: flash_status_pkg::MODE_POLL_BIT;
			erase_ff <= is_erase_i;
			exp_ff <= expect_data_i;
			addr_ff <= poll_addr_i;
		end
	end

	// Evaluation bookkeeping.  The timeout bit is noted but acted on only
	// after one further status read, since both status bits can move together.
	always_ff @(posedge mclk_i) begin
		if (srst_i || (state_ff == flash_status_pkg::ST_IDLE)) begin
			prev_ff <= 8'h00;
			have_prev_ff <= 1'b0;
			saw_timeout_ff <= 1'b0;
			want_data_ff <= 1'b0;
		end else if (state_ff == flash_status_pkg::ST_EVAL) begin
			prev_ff <= rd_ff;
			have_prev_ff <= 1'b1;
			if (mode_ff == flash_status_pkg::MODE_POLL_BIT) begin
				saw_timeout_ff <= timeout_seen;
				want_data_ff <= poll_true;
			end else if (have_prev_ff) begin
				saw_timeout_ff <= timeout_seen && toggled;
				want_data_ff <= !toggled;
			end
		end
	end

	// Result outputs stay until the next start.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
			final_ff <= 8'h00;
			sect_ff <= 1'b0;
		end else if (state_ff == flash_status_pkg::ST_IDLE && start_i) begin
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
			sect_ff <= 1'b0;
		end else if (state_ff == flash_status_pkg::ST_EVAL && want_data_ff && !abort_i) begin
			done_ff <= 1'b1;
			final_ff <= rd_ff;
		end else if (state_ff == flash_status_pkg::ST_WR_HIGH &&
			nxt_state == flash_status_pkg::ST_FINISH) begin
			done_ff <= 1'b1;
			fail_ff <= 1'b1;
		end else if (state_ff == flash_status_pkg::ST_EVAL && have_prev_ff && sect_toggled) begin
			sect_ff <= 1'b1;
		end
	end
endmodule

// File: flash_status_poller_assertions.sv
// Port checker for the status poller.
`timescale 1ns/1ps
module flash_status_poller_assertions (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic fail_o,
	input wire logic [18:0] addr_o,
	input wire logic ce_n_o,
	input wire logic oe_n_o,
	input wire logic we_n_o,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe_o
);
	// All checks share the one clock and its reset.
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	property p_start; start_i && !busy_o |=> busy_o && !done_o; endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_rd; !oe_n_o |-> !ce_n_o && !dq_oe_o; endproperty
	a_rd: assert property (p_rd) else $error("bad read strobes");
	property p_rdlen; $fell(oe_n_o) |-> !oe_n_o[*4] ##1 oe_n_o[*2]; endproperty
	a_rdlen: assert property (p_rdlen) else $error("read length");
	property p_cmd; !we_n_o |-> oe_n_o && dq_oe_o && dq_o == 8'hf0; endproperty
	a_cmd: assert property (p_cmd) else $error("bad reset write");
	property p_wrlen; $fell(we_n_o) |-> !we_n_o[*4] ##1 we_n_o[*2]; endproperty
	a_wrlen: assert property (p_wrlen) else $error("write length");
	property p_wrfail; $fell(we_n_o) |-> ##[5:8] (done_o && fail_o); endproperty
	a_wrfail: assert property (p_wrfail) else $error("no fail after write");
	// Failure is reported only once the bus has been let go; the finish cycle still counts busy.
	property p_fail; fail_o |-> done_o && ce_n_o && !dq_oe_o; endproperty
	a_fail: assert property (p_fail) else $error("fail without done");
	property p_addr; !oe_n_o && !$past(oe_n_o) |-> $stable(addr_o); endproperty
	a_addr: assert property (p_addr) else $error("address moved");
endmodule
bind flash_status_poller flash_status_poller_assertions chk_u (.mclk_i(mclk_i),
	.srst_i(srst_i), .start_i(start_i), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o),
	.addr_o(addr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .dq_o(dq_o),
	.dq_oe_o(dq_oe_o));

// File: flash_dev_model.sv
// Behavioural flash device that answers status reads.
`timescale 1ns/1ps
module flash_dev_model (
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [7:0] dq_i,
	input wire logic dq_oe_i,
	output logic [7:0] dq_o
);
	int left = 0;
	logic er = 0, fl = 0, sect = 0, sus = 0, tg = 0, tg2 = 0;
	logic [7:0] pd = 8'h00, arr = 8'h00, last = 8'h00;
	wire busy = (left > 0) || fl;
	// A suspended erase reads as poll bit 1 with the first toggle bit frozen.
	wire [7:0] st = {er ? sus : ~pd[7], tg, fl && left == 0, 2'b00,
		sect ? tg2 : arr[2], 2'b00};
	wire [7:0] rd_val = busy ? st : arr;
	// Released bus shows the inverse of the last byte, not a held value.
	assign dq_o = (oe_n_i || ce_n_i) ? ~last : rd_val;
	// A protected job shows busy status for n reads, then the old array byte.
	// A forced failure stands for a pulse overrun or a one written over a zero.
	task arm(input int n, input logic e, input logic f, input logic s, input logic [7:0] d,
		input logic p, input logic u);
		left = n;
		er = e;
		fl = f;
		sect = s;
		sus = u;
		pd = d;
		if (!p) arr = e ? 8'hff : d;
	endtask
	// Each finished read flips the second toggle bit and, unless the erase is suspended, steps the algorithm
	// and flips the first toggle bit; status is live from the first read after the command, so no read is lost at the start.
	always @(posedge oe_n_i) begin
		last = rd_val;
		if (!sus) tg = ~tg;
		tg2 = ~tg2;
		if (left > 0 && !sus) left--;
	end
	// Reset command leaves the failed state for array reads.
	always @(posedge we_n_i) if (dq_oe_i && dq_i == 8'hf0) fl = 0;
endmodule

// File: flash_write_status_reporting_test.sv
// Testbench for the status poller against the flash model.
`timescale 1ns/1ps
module flash_write_status_reporting_test;
	logic mclk_i = 0, srst_i = 1, start_i = 0, toggle_mode_i = 0, is_erase_i = 0, abort_i = 0;
	logic [18:0] poll_addr_i = 0;
	logic [7:0] expect_data_i = 0, final_data_o, dq_i, dq_o;
	logic busy_o, done_o, fail_o, in_erase_sector_o, ce_n_o, oe_n_o, we_n_o, dq_oe_o;
	logic [18:0] addr_o;
	int err_total = 0, tests_run = 0, cyc = 0, s;
	always #10 mclk_i = ~mclk_i;
	flash_status_poller dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i),
		.toggle_mode_i(toggle_mode_i), .poll_addr_i(poll_addr_i), .expect_data_i(expect_data_i),
		.is_erase_i(is_erase_i), .abort_i(abort_i), .busy_o(busy_o), .done_o(done_o),
		.fail_o(fail_o), .final_data_o(final_data_o), .in_erase_sector_o(in_erase_sector_o),
		.addr_o(addr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .dq_i(dq_i),
		.dq_o(dq_o), .dq_oe_o(dq_oe_o));
	flash_dev_model dev_u (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .dq_i(dq_o),
		.dq_oe_i(dq_oe_o), .dq_o(dq_i));
	// Hang guard well above the longest expected run.
	always @(posedge mclk_i) if (++cyc == 20000) begin
		err_total++;
		tally_and_finish();
	end
	task tally_and_finish;
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Bench copy of the array byte at the polled address.
	logic [7:0] exp_arr = 8'h00;
	task chk(input logic [18:0] got, input logic [18:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One polling job; expectations come from the job settings and the bench array copy.
	// A protected job (p) leaves the array alone; u keeps the erase suspended.
	task job(input logic tm, input logic er, input logic fl, input logic sc, input int n,
		input logic [7:0] d, input logic ab, input logic p, input logic u);
		int w;
		logic [18:0] a;
		a = 19'($urandom);
		if (!p) exp_arr = er ? 8'hff : d;
		dev_u.arm(n, er, fl, sc, d, p, u);
		@(posedge mclk_i);
		start_i <= 1;
		toggle_mode_i <= tm;
		is_erase_i <= er;
		expect_data_i <= d;
		poll_addr_i <= a;
		abort_i <= ab;
		@(posedge mclk_i);
		start_i <= 0;
		w = 0;
		@(negedge mclk_i);
		chk(busy_o, 1);
		while (busy_o !== 1'b0 && w < 3000) begin
			@(negedge mclk_i);
			w++;
		end
		chk(done_o, !ab);
		chk(fail_o, fl && !ab);
		chk(addr_o, a);
		if (u) chk(final_data_o & 8'ha0, 8'h80);
		else if (!fl && !ab) chk(final_data_o, exp_arr);
		if (!ab) chk(in_erase_sector_o, sc);
	endtask
	initial begin
		s = $urandom(32'h0000_a195);
		repeat (4) @(posedge mclk_i);
		srst_i <= 0;
		for (int i = 0; i < 16; i++)
			job(i[0], i[1], i[2], i[1] & i[3], 2 + $urandom % 4, 8'($urandom), 0, 0, 0);
		job(1, 0, 0, 0, 3, 8'h5a, 0, 1, 0);
		job(1, 1, 0, 0, 4, 8'h00, 0, 1, 0);
		job(1, 1, 0, 1, 5, 8'h00, 0, 0, 1);
		job(1, 0, 0, 0, 50, 8'h3c, 1, 0, 0);
		job(0, 1, 1, 1, 3, 8'h00, 0, 0, 0);
		tally_and_finish();
	end
endmodule
